// >>> design/pmt_defs.svh
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

// ==========================================
// Bus geometry and register map
`define PMT_ADDR_W       8
`define PMT_DATA_W       32
`define PMT_OFF_CONTROL  8'h00
`define PMT_OFF_COUNT    8'h04
`define PMT_OFF_PERIOD   8'h08
`define PMT_OFF_FLAGS    8'h0c
`define PMT_RESP_OKAY    2'h0
`define PMT_RESP_SLVERR  2'h2

// ==========================================
// Control and flags register fields
`define PMT_CTL_PRE_LSB  0
`define PMT_CTL_PRE_MSB  1
`define PMT_CTL_ON_BIT   2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_POST_MSB 6
`define PMT_FLAG_BIT     0

// ==========================================
// Reset values and counts
`define PMT_COUNT_RST    8'h00
`define PMT_PERIOD_RST   8'hff
`define PMT_QTR_LAST     2'h3
`define PMT_PRE_LAST_1   4'h0
`define PMT_PRE_LAST_4   4'h3
`define PMT_PRE_LAST_16  4'hf
`define PMT_PRE_SEL_1    2'h0
`define PMT_PRE_SEL_4    2'h1
`endif

// >>> design/pmt_pkg.sv
package pmt_pkg;
	typedef logic [7:0] pmt_byte_t;
	typedef logic [1:0] pmt_pre_sel_t;
	typedef logic [3:0] pmt_post_sel_t;
	typedef logic [1:0] pmt_resp_t;
endpackage

// >>> design/pmt_timer_if.sv
`timescale 1ns/100ps
interface pmt_timer_if;
	logic                   timer_on;
	pmt_pkg::pmt_pre_sel_t  prescale_select;
	pmt_pkg::pmt_post_sel_t postscale_select;
	pmt_pkg::pmt_byte_t     period_value;
	logic                   count_wr;
	logic                   ctrl_wr;
	pmt_pkg::pmt_byte_t     wr_data;
	pmt_pkg::pmt_byte_t     timer_count;
	logic                   post_pulse;

	modport ctrl (output timer_on, prescale_select, postscale_select, period_value,
		count_wr, ctrl_wr, wr_data, input timer_count, post_pulse);
	modport core (input timer_on, prescale_select, postscale_select, period_value,
		count_wr, ctrl_wr, wr_data, output timer_count, post_pulse);
endinterface

// >>> design/pmt_core.sv
`timescale 1ns/100ps
`include "pmt_defs.svh"
module pmt_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register side
	pmt_timer_if.core tif
);
	logic [1:0]             quarter;
	logic [3:0]             pre_cnt;
	logic [3:0]             pre_last;
	pmt_pkg::pmt_post_sel_t post_cnt;
	pmt_pkg::pmt_byte_t     count;
	logic                   post_pulse;
	logic                   instr_tick;
	logic                   pre_out;
	logic                   match;
	logic                   scaler_clear;

	// ==========================================
	// Instruction clock and prescaler
	assign instr_tick   = (quarter == `PMT_QTR_LAST);
	assign scaler_clear = tif.count_wr | tif.ctrl_wr;
	assign match        = (count == tif.period_value);

	always_comb begin
		case (tif.prescale_select)
			`PMT_PRE_SEL_1: pre_last = `PMT_PRE_LAST_1;
			`PMT_PRE_SEL_4: pre_last = `PMT_PRE_LAST_4;
			default:        pre_last = `PMT_PRE_LAST_16;
		endcase
	end

	assign pre_out = instr_tick & tif.timer_on & (pre_cnt >= pre_last) & ~scaler_clear;

	// Free-running divide by four of the core clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			quarter <= 2'h0;
		end else begin
			quarter <= quarter + 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt <= 4'h0;
		end else if (scaler_clear) begin
			pre_cnt <= 4'h0;
		end else if (pre_out) begin
			pre_cnt <= 4'h0;
		end else if (instr_tick && tif.timer_on) begin
			pre_cnt <= pre_cnt + 4'h1;
		end
	end

	// ==========================================
	// Count register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= `PMT_COUNT_RST;
		end else if (tif.count_wr) begin
			count <= tif.wr_data;
		end else if (pre_out) begin
			if (match) begin
				count <= `PMT_COUNT_RST;
			end else begin
				count <= count + 8'h01;
			end
		end
	end

	// ==========================================
	// Postscaler
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			post_cnt   <= 4'h0;
			post_pulse <= 1'b0;
		end else if (scaler_clear) begin
			post_cnt   <= 4'h0;
			post_pulse <= 1'b0;
		end else if (pre_out && match) begin
			if (post_cnt >= tif.postscale_select) begin
				post_cnt   <= 4'h0;
				post_pulse <= 1'b1;
			end else begin
				post_cnt   <= post_cnt + 4'h1;
				post_pulse <= 1'b0;
			end
		end else begin
			post_pulse <= 1'b0;
		end
	end

	assign tif.timer_count = count;
	assign tif.post_pulse  = post_pulse;
endmodule

// >>> design/pmt_top.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pmt_defs.svh"
module pmt_top (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	// AXI4-Lite write address
	input  wire logic [`PMT_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [`PMT_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [`PMT_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	// AXI4-Lite read data
	output logic [`PMT_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	// ==========================================
	// Declarations
	pmt_timer_if tif ();

	logic [`PMT_ADDR_W-1:0] aw_addr;
	logic                   aw_have;
	logic [`PMT_DATA_W-1:0] w_data;
	logic [3:0]             w_strb;
	logic                   w_have;
	logic                   do_write;
	logic                   wr_byte0;
	logic                   wr_hit_control;
	logic                   wr_hit_count;
	logic                   wr_hit_period;
	logic                   wr_hit_flags;
	logic                   wr_mapped;
	logic                   next_aw_have;
	logic                   next_w_have;
	logic                   next_bvalid;
	logic                   next_rvalid;
	logic                   ar_take;
	logic                   rd_mapped;
	logic [`PMT_DATA_W-1:0] rd_word;
	pmt_pkg::pmt_resp_t     rd_resp;

	logic                   timer_on;
	pmt_pkg::pmt_pre_sel_t  prescale_select;
	pmt_pkg::pmt_post_sel_t postscale_select;
	pmt_pkg::pmt_byte_t     period_value;
	logic                   match_irq_flag;
	pmt_pkg::pmt_byte_t     control_byte;

	// ==========================================
	// Write channel capture
	// Address and data are held separately, so either may arrive first.
	assign do_write = aw_have & w_have & ~s_axi_bvalid;

	always_comb begin
		next_aw_have = aw_have;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_have = 1'b1;
		end else if (do_write) begin
			next_aw_have = 1'b0;
		end
	end

	always_comb begin
		next_w_have = w_have;
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_have = 1'b1;
		end else if (do_write) begin
			next_w_have = 1'b0;
		end
	end

	always_comb begin
		next_bvalid = s_axi_bvalid;
		if (do_write) begin
			next_bvalid = 1'b1;
		end else if (s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			aw_have       <= next_aw_have;
			s_axi_awready <= ~next_aw_have;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_have       <= 1'b0;
			w_data       <= '0;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			w_have       <= next_w_have;
			s_axi_wready <= ~next_w_have;
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// ==========================================
	// Write decode and response
	assign wr_hit_control = (aw_addr == `PMT_OFF_CONTROL);
	assign wr_hit_count   = (aw_addr == `PMT_OFF_COUNT);
	assign wr_hit_period  = (aw_addr == `PMT_OFF_PERIOD);
	assign wr_hit_flags   = (aw_addr == `PMT_OFF_FLAGS);
	assign wr_mapped      = wr_hit_control | wr_hit_count | wr_hit_period | wr_hit_flags;
	// All fields live in byte lane 0; a write without that lane has no effect.
	assign wr_byte0       = do_write & w_strb[0];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PMT_RESP_OKAY;
		end else begin
			s_axi_bvalid <= next_bvalid;
			if (do_write) begin
				s_axi_bresp <= wr_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
			end
		end
	end

	// ==========================================
	// Control and period registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_on         <= 1'b0;
			prescale_select  <= 2'h0;
			postscale_select <= 4'h0;
		end else if (wr_byte0 && wr_hit_control) begin
			timer_on         <= w_data[`PMT_CTL_ON_BIT];
			prescale_select  <= w_data[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB];
			postscale_select <= w_data[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			period_value <= `PMT_PERIOD_RST;
		end else if (wr_byte0 && wr_hit_period) begin
			period_value <= w_data[7:0];
		end
	end

	// ==========================================
	// Match flag
	// Write one to clear; a postscaler pulse in the same cycle wins.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			match_irq_flag <= 1'b0;
		end else if (tif.post_pulse) begin
			match_irq_flag <= 1'b1;
		end else if (wr_byte0 && wr_hit_flags && w_data[`PMT_FLAG_BIT]) begin
			match_irq_flag <= 1'b0;
		end
	end

	// ==========================================
	// Timer core hookup
	assign tif.timer_on         = timer_on;
	assign tif.prescale_select  = prescale_select;
	assign tif.postscale_select = postscale_select;
	assign tif.period_value     = period_value;
	assign tif.count_wr         = wr_byte0 & wr_hit_count;
	assign tif.ctrl_wr          = wr_byte0 & wr_hit_control;
	assign tif.wr_data          = w_data[7:0];

	pmt_core u_core (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.tif      (tif.core)
	);

	// ==========================================
	// Read channel
	assign ar_take = s_axi_arvalid & s_axi_arready;

	always_comb begin
		control_byte = 8'h00;
		control_byte[`PMT_CTL_ON_BIT] = timer_on;
		control_byte[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB] = prescale_select;
		control_byte[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB] = postscale_select;
	end

	always_comb begin
		rd_word   = '0;
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			`PMT_OFF_CONTROL: rd_word[7:0] = control_byte;
			`PMT_OFF_COUNT:   rd_word[7:0] = tif.timer_count;
			`PMT_OFF_PERIOD:  rd_word[7:0] = period_value;
			`PMT_OFF_FLAGS:   rd_word[`PMT_FLAG_BIT] = match_irq_flag;
			default:          rd_mapped = 1'b0;
		endcase
		rd_resp = rd_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
	end

	always_comb begin
		next_rvalid = s_axi_rvalid;
		if (ar_take) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// One read in flight; arready drops until the data is taken.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `PMT_RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (ar_take) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_resp;
			end
		end
	end
endmodule

// >>> verification/pmt_top_checker.sv
`timescale 1ns/100ps
`include "pmt_defs.svh"
module pmt_top_checker (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        reset_n,
	// Write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// Write path
	sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_wr_resp; ##2 s_axi_bvalid; endsequence
	property p_wr_lat; s_wr_both |-> s_wr_resp; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response not two edges after handshake");
	property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_drop: assert property (p_aw_drop) else $error("address slot not closed after capture");
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {`PMT_RESP_OKAY, `PMT_RESP_SLVERR}; endproperty
	a_bresp: assert property (p_bresp) else $error("illegal write response code");
	// ==========================================
	// Read path
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data not one edge after address");
	property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_rd_done: assert property (p_rd_done) else $error("read channel not freed after accept");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address taken while data pending");
	property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
	property p_rd_err; s_axi_rvalid && s_axi_rresp != `PMT_RESP_OKAY |-> s_axi_rdata == 32'h0000_0000; endproperty
	a_rd_err: assert property (p_rd_err) else $error("error read carries data");
endmodule
bind pmt_top pmt_top_checker pmt_top_checker_i (.core_clk(core_clk), .reset_n(reset_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));

// >>> verification/tb_period_match_timer.sv
`timescale 1ns/100ps
`include "pmt_defs.svh"
module tb_period_match_timer;
	logic        core_clk, reset_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] dat;
	int          failures, samples_checked, ticks;
	pmt_top pmt_top_i (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ==========================================
	// Reporting
	task automatic print_verdict;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: response %h expected %h", $time, got, exp);
		end
	endtask
	// ==========================================
	// Bus master: payload held until each channel is taken
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 100) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 100) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_write(a, d, 4'hf, rsp);
		check_resp(rsp, `PMT_RESP_OKAY);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus_read(a, dat, rsp);
		check_resp(rsp, `PMT_RESP_OKAY);
		check_data(dat, exp);
	endtask
	function automatic logic [31:0] ctl(input int on, input int pre, input int post);
		return 32'(post << `PMT_CTL_POST_LSB | on << `PMT_CTL_ON_BIT | pre << `PMT_CTL_PRE_LSB);
	endfunction
	// ==========================================
	// Scenarios
	int pre_t[6]  = '{0, 1, 2, 3, 0, 1};
	int post_t[6] = '{0, 1, 0, 0, 15, 2};
	int per_t[6]  = '{3, 2, 1, 1, 0, 9};
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		reset_n = 1'b0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		rd_chk(`PMT_OFF_CONTROL, 32'h0000_0000);
		rd_chk(`PMT_OFF_COUNT, 32'h0000_0000);
		rd_chk(`PMT_OFF_PERIOD, 32'h0000_00ff);
		rd_chk(`PMT_OFF_FLAGS, 32'h0000_0000);
		wr(`PMT_OFF_COUNT, 32'h0000_0040);
		repeat (100) @(posedge core_clk);
		rd_chk(`PMT_OFF_COUNT, 32'h0000_0040);
		wr(`PMT_OFF_CONTROL, ctl(0, 2, 5));
		rd_chk(`PMT_OFF_CONTROL, ctl(0, 2, 5));
		rd_chk(`PMT_OFF_COUNT, 32'h0000_0040);
		bus_write(`PMT_OFF_COUNT, 32'h0000_0077, 4'h0, rsp);
		check_resp(rsp, `PMT_RESP_OKAY);
		rd_chk(`PMT_OFF_COUNT, 32'h0000_0040);
		bus_write(8'h10, 32'h0000_0011, 4'hf, rsp);
		check_resp(rsp, `PMT_RESP_SLVERR);
		bus_read(8'h10, dat, rsp);
		check_resp(rsp, `PMT_RESP_SLVERR);
		check_data(dat, 32'h0000_0000);
		// Flag time is (period+1)*(post+1)*prescale ticks of four clocks; margins cover tick phase
		for (int i = 0; i < 6; i++) begin
			wr(`PMT_OFF_CONTROL, ctl(0, pre_t[i], post_t[i]));
			wr(`PMT_OFF_PERIOD, per_t[i]);
			wr(`PMT_OFF_COUNT, 32'h0000_0000);
			wr(`PMT_OFF_FLAGS, 32'h0000_0001);
			rd_chk(`PMT_OFF_FLAGS, 32'h0000_0000);
			wr(`PMT_OFF_CONTROL, ctl(1, pre_t[i], post_t[i]));
			ticks = (per_t[i] + 1) * (post_t[i] + 1) * (pre_t[i] == 0 ? 1 : pre_t[i] == 1 ? 4 : 16);
			repeat (4 * ticks - 8) @(posedge core_clk);
			rd_chk(`PMT_OFF_FLAGS, 32'h0000_0000);
			repeat (20) @(posedge core_clk);
			rd_chk(`PMT_OFF_FLAGS, 32'h0000_0001);
		end
		// Repeated writes keep restarting the divide by 16, so no match can complete
		for (int j = 0; j < 2; j++) begin
			wr(`PMT_OFF_CONTROL, ctl(0, 2, 0));
			wr(`PMT_OFF_PERIOD, 32'h0000_0000);
			wr(`PMT_OFF_FLAGS, 32'h0000_0001);
			wr(`PMT_OFF_CONTROL, ctl(1, 2, 0));
			repeat (3) begin
				repeat (40) @(posedge core_clk);
				if (j == 0) wr(`PMT_OFF_COUNT, 32'h0000_0000);
				else wr(`PMT_OFF_CONTROL, ctl(1, 2, 0));
			end
			rd_chk(`PMT_OFF_FLAGS, 32'h0000_0000);
		end
		// Reset in mid-run with the timer going must restore the count, period and control registers
		wr(`PMT_OFF_COUNT, 32'h0000_0055);
		wr(`PMT_OFF_PERIOD, 32'h0000_0033);
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		rd_chk(`PMT_OFF_COUNT, 32'h0000_0000);
		rd_chk(`PMT_OFF_PERIOD, 32'h0000_00ff);
		rd_chk(`PMT_OFF_CONTROL, 32'h0000_0000);
		print_verdict();
	end
endmodule
